// ---- common/corr_defines.svh ----
// Constants for the binary correlator array: offsets, field positions, resets, counts.
`ifndef CORR_DEFINES_SVH
`define CORR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the register bus
// ----------------------------------------------------------------------------
`define CORR_REG_CTRL          8'h00
`define CORR_REG_STATUS        8'h04
`define CORR_REG_SCORE         8'h08

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CORR_CTRL_XFER_BIT     0
`define CORR_CFG_WIN8_BIT      0
`define CORR_CFG_DUAL_BIT      1
`define CORR_STAT_CFG_LSB      0
`define CORR_STAT_DELAY_LSB    8
`define CORR_STAT_OE_BIT       12
`define CORR_OFF_HI_W          5

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define CORR_CFG_RESET         8'h00
`define CORR_OFFSET_RESET      13'h0000
`define CORR_DELAY_RESET       4'h0
`define CORR_STAGES            8
`define CORR_TAPS              32
`define CORR_SYNC_W            44
`define CORR_SYNC_RESET        44'hC00_0000_0003

`endif

// ---- common/corr_pkg.sv ----
// Types shared by the correlator array files.
package corr_pkg;

  typedef logic [12:0] score_t;
  typedef logic [8:0]  aux_t;
  typedef logic [7:0]  byte_t;

  typedef enum logic [2:0] {
    DEST_MASK    = 3'h0,
    DEST_CONFIG  = 3'h1,
    DEST_OFFA_HI = 3'h2,
    DEST_OFFA_LO = 3'h3,
    DEST_DELAY   = 3'h4,
    DEST_OFFB_HI = 3'h5,
    DEST_OFFB_LO = 3'h6,
    DEST_RSVD    = 3'h7
  } ctrl_dest_t;

endpackage

// ---- logic/corr_sync.sv ----
// Two-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/10ps
`default_nettype none

module corr_sync #(
  parameter int          WIDTH     = 44,
  parameter logic [43:0] RESET_VAL = 44'h000_0000_0003
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1 || WIDTH > 44) begin : g_bad_width
    $error("corr_sync width out of range");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL[WIDTH-1:0];
      sync_reg <= RESET_VAL[WIDTH-1:0];
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule

`default_nettype wire

// ---- logic/corr_stage.sv ----
// One correlation stage: data shift line, reference and mask preload and cell latches.
`timescale 1ns/10ps
`default_nettype none

module corr_stage #(
  parameter int TAPS    = 32,
  parameter int SCORE_W = 6
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               data_in,
  input  wire logic               ref_in,
  input  wire logic               ref_shift,
  input  wire logic               mask_in,
  input  wire logic               mask_shift,
  input  wire logic               transfer,
  output logic                    data_last_next,
  output logic                    ref_last,
  output logic                    mask_last,
  output logic      [SCORE_W-1:0] score
);

  logic [TAPS-1:0]    data_reg,     data_next;
  logic [TAPS-1:0]    ref_pre_reg,  ref_pre_next;
  logic [TAPS-1:0]    mask_pre_reg, mask_pre_next;
  logic [TAPS-1:0]    ref_cell_reg, ref_cell_next;
  logic [TAPS-1:0]    mask_cell_reg, mask_cell_next;
  logic [SCORE_W-1:0] score_reg,    score_next;

  if (TAPS < 2 || (2 ** SCORE_W) <= TAPS) begin : g_bad_taps
    $error("corr_stage taps and score width do not fit");
  end

  always_comb begin
    data_next     = {data_reg[TAPS-2:0], data_in};
    ref_pre_next  = ref_shift  ? {ref_pre_reg[TAPS-2:0], ref_in}   : ref_pre_reg;
    mask_pre_next = mask_shift ? {mask_pre_reg[TAPS-2:0], mask_in} : mask_pre_reg;
    ref_cell_next  = transfer ? ref_pre_reg  : ref_cell_reg;
    mask_cell_next = transfer ? mask_pre_reg : mask_cell_reg;
    score_next = '0;
    for (int i = 0; i < TAPS; i++) begin
      score_next = score_next
                 + SCORE_W'((~(data_reg[i] ^ ref_cell_reg[i])) & mask_cell_reg[i]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg      <= '0;
      ref_pre_reg   <= '0;
      mask_pre_reg  <= '0;
      ref_cell_reg  <= '0;
      mask_cell_reg <= '0;
      score_reg     <= '0;
    end else begin
      data_reg      <= data_next;
      ref_pre_reg   <= ref_pre_next;
      mask_pre_reg  <= mask_pre_next;
      ref_cell_reg  <= ref_cell_next;
      mask_cell_reg <= mask_cell_next;
      score_reg     <= score_next;
    end
  end

  assign data_last_next = data_next[TAPS-1];
  assign ref_last       = ref_pre_reg[TAPS-1];
  assign mask_last      = mask_pre_reg[TAPS-1];
  assign score          = score_reg;

endmodule

`default_nettype wire

// ---- logic/corr_top.sv ----
// Binary correlator array top: pin loading, eight stages, scoring, output muxes, APB slave.
`timescale 1ns/10ps
`default_nettype none
`include "corr_defines.svh"

module corr_top #(
  parameter int STAGES = `CORR_STAGES,
  parameter int TAPS   = `CORR_TAPS
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire corr_pkg::byte_t  ref_bus_in,
  input  wire logic             ref_load_n,
  input  wire corr_pkg::byte_t  ctrl_bus_in,
  input  wire logic             ctrl_load_n,
  input  wire logic [2:0]       ctrl_addr,
  input  wire corr_pkg::byte_t  sample_bus_in,
  input  wire corr_pkg::score_t chain_score_in,
  input  wire logic             array_transfer_n,
  input  wire logic             aux_out_en_n,
  output corr_pkg::byte_t       sample_bus_out,
  output corr_pkg::score_t      chain_score_out,
  output corr_pkg::aux_t        aux_bus_out,
  output logic                  aux_bus_oe
);

  import corr_pkg::*;

  localparam int SCORE_W = $clog2(TAPS + 1);

  if (STAGES != 8 || TAPS < 2 || TAPS > 32) begin : g_bad_geometry
    $error("corr_top supports eight stages of 2 to 32 taps");
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers and strobe edges
  // --------------------------------------------------------------------------
  logic [`CORR_SYNC_W-1:0] pins_raw, pins_s;
  logic       ref_ld_s, ctrl_ld_s, xfer_n_s, oe_n_s;
  logic [2:0] addr_s;
  byte_t      ctrl_s, ref_s, sample_s;
  score_t     chain_in_s;

  assign pins_raw = {aux_out_en_n, array_transfer_n, chain_score_in, sample_bus_in,
                     ref_bus_in, ctrl_bus_in, ctrl_addr, ctrl_load_n, ref_load_n};

  corr_sync #(
    .WIDTH     (`CORR_SYNC_W),
    .RESET_VAL (`CORR_SYNC_RESET)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (pins_raw),
    .dout  (pins_s)
  );

  assign {oe_n_s, xfer_n_s, chain_in_s, sample_s, ref_s, ctrl_s, addr_s, ctrl_ld_s,
          ref_ld_s} = pins_s;

  logic ref_ld_prev_reg,  ref_ld_prev_next;
  logic ctrl_ld_prev_reg, ctrl_ld_prev_next;
  logic ref_rise, ctrl_rise;

  assign ref_rise  = ref_ld_s  & ~ref_ld_prev_reg;
  assign ctrl_rise = ctrl_ld_s & ~ctrl_ld_prev_reg;

  // --------------------------------------------------------------------------
  // Control registers loaded from the control bus
  // --------------------------------------------------------------------------
  byte_t      config_reg,   config_next;
  score_t     offset_a_reg, offset_a_next;
  score_t     offset_b_reg, offset_b_next;
  logic [3:0] delay_reg,    delay_next;
  logic       win8, dual, mask_load;
  ctrl_dest_t dest;

  assign dest      = ctrl_dest_t'(addr_s);
  assign win8      = config_reg[`CORR_CFG_WIN8_BIT];
  assign dual      = config_reg[`CORR_CFG_DUAL_BIT];
  // Mask load on control strobe edge.
  assign mask_load = ctrl_rise && (dest == DEST_MASK);

  always_comb begin
    ref_ld_prev_next  = ref_ld_s;
    ctrl_ld_prev_next = ctrl_ld_s;
    config_next   = config_reg;
    offset_a_next = offset_a_reg;
    offset_b_next = offset_b_reg;
    delay_next    = delay_reg;
    if (ctrl_rise) begin
      case (dest)
        DEST_CONFIG:  config_next = ctrl_s;
        DEST_OFFA_HI: offset_a_next[12:8] = ctrl_s[`CORR_OFF_HI_W-1:0];
        DEST_OFFA_LO: offset_a_next[7:0]  = ctrl_s;
        DEST_DELAY:   delay_next = ctrl_s[3:0];
        DEST_OFFB_HI: offset_b_next[12:8] = ctrl_s[`CORR_OFF_HI_W-1:0];
        DEST_OFFB_LO: offset_b_next[7:0]  = ctrl_s;
        default:      config_next = config_reg;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Correlation stages
  // --------------------------------------------------------------------------
  logic [7:0]         st_data_in, st_ref_in, st_mask_in;
  logic [7:0]         st_data_last_next, st_ref_last, st_mask_last;
  logic [SCORE_W-1:0] st_score [8];
  logic               soft_xfer_reg, soft_xfer_next;
  logic               transfer;
  logic [7:0]         st_tail_reg,   st_tail_next;

  // Transfer from pin or bus pulse.
  assign transfer = ~xfer_n_s | soft_xfer_reg;

  // Registered last element feeds the next stage.
  assign st_tail_next = st_data_last_next;

  for (genvar i = 0; i < 8; i++) begin : g_stage
    if (i == 0) begin : g_first
      // First stage fed by bit 7.
      assign st_data_in[0] = sample_s[7];
      // Reference bit 7 feeds stage one.
      assign st_ref_in[0]  = ref_s[7];
      assign st_mask_in[0] = ctrl_s[7];
    end else begin : g_rest
      assign st_data_in[i] = win8 ? sample_s[7-i] : st_tail_reg[i-1];
      assign st_ref_in[i]  = win8 ? ref_s[7-i]    : st_ref_last[i-1];
      assign st_mask_in[i] = win8 ? ctrl_s[7-i]   : st_mask_last[i-1];
    end

    corr_stage #(
      .TAPS    (TAPS),
      .SCORE_W (SCORE_W)
    ) u_stage (
      .clk            (pclk),
      .rst_n          (presetn),
      .data_in        (st_data_in[i]),
      .ref_in         (st_ref_in[i]),
      .ref_shift      (ref_rise),
      .mask_in        (st_mask_in[i]),
      .mask_shift     (mask_load),
      .transfer       (transfer),
      .data_last_next (st_data_last_next[i]),
      .ref_last       (st_ref_last[i]),
      .mask_last      (st_mask_last[i]),
      .score          (st_score[i])
    );
  end

  // --------------------------------------------------------------------------
  // Scoring
  // --------------------------------------------------------------------------
  // Sums stages lo..hi; weighted mode gives the first stage the top weight.
  function automatic score_t stage_sum(input logic [SCORE_W-1:0] s [8],
                                       input logic weighted,
                                       input int lo,
                                       input int hi);
    score_t acc;
    acc = '0;
    for (int k = 0; k < 8; k++) begin
      if (k >= lo && k <= hi) begin
        if (weighted) begin
          acc = acc + (score_t'(s[k]) << (7 - k));
        end else begin
          acc = acc + score_t'(s[k]);
        end
      end
    end
    return acc;
  endfunction

  score_t sum_all, sum_a, sum_b;

  assign sum_all = stage_sum(st_score, win8, 0, 7);
  assign sum_a   = stage_sum(st_score, 1'b0, 0, 3);
  assign sum_b   = stage_sum(st_score, 1'b0, 4, 7);

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  byte_t  sample_out_reg, sample_out_next;
  score_t chain_out_reg,  chain_out_next;
  aux_t   aux_reg,        aux_next;
  logic   aux_oe_reg,     aux_oe_next;

  always_comb begin
    sample_out_next = '0;
    if (win8) begin
      for (int k = 0; k < 8; k++) begin
        sample_out_next[7-k] = st_data_last_next[k];
      end
    end else begin
      // Long window exits on bit 7.
      sample_out_next[7] = st_data_last_next[7];
    end
    if (dual) begin
      chain_out_next = sum_a + offset_a_reg;
      chain_out_next[12:9] = '0;
      aux_next = aux_t'(sum_b + offset_b_reg);
    end else begin
      chain_out_next = sum_all + offset_a_reg + chain_in_s;
      aux_next = '0;
      for (int k = 0; k < 8; k++) begin
        aux_next[7-k] = st_ref_last[k];
      end
    end
    aux_oe_next = ~oe_n_s;
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  logic [31:0] prdata_reg,  prdata_next;
  logic        pready_reg,  pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        setup, access, mapped;

  assign setup  = psel & ~penable;
  assign access = psel & penable & pready_reg;
  assign mapped = (paddr == `CORR_REG_CTRL) || (paddr == `CORR_REG_STATUS)
               || (paddr == `CORR_REG_SCORE);

  always_comb begin
    pready_next    = setup;
    pslverr_next   = setup & ~mapped;
    prdata_next    = '0;
    soft_xfer_next = 1'b0;
    if (setup && !pwrite) begin
      case (paddr)
        `CORR_REG_STATUS: begin
          prdata_next[`CORR_STAT_CFG_LSB +: 8]   = config_reg;
          prdata_next[`CORR_STAT_DELAY_LSB +: 4] = delay_reg;
          prdata_next[`CORR_STAT_OE_BIT]         = aux_oe_reg;
        end
        `CORR_REG_SCORE: prdata_next[12:0] = chain_out_reg;
        default:         prdata_next = '0;
      endcase
    end
    if (access && pwrite && paddr == `CORR_REG_CTRL) begin
      soft_xfer_next = pwdata[`CORR_CTRL_XFER_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // State registers
  // --------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ld_prev_reg  <= 1'b1;
      ctrl_ld_prev_reg <= 1'b1;
      config_reg       <= `CORR_CFG_RESET;
      offset_a_reg     <= `CORR_OFFSET_RESET;
      offset_b_reg     <= `CORR_OFFSET_RESET;
      delay_reg        <= `CORR_DELAY_RESET;
      soft_xfer_reg    <= 1'b0;
      st_tail_reg      <= '0;
      sample_out_reg   <= '0;
      chain_out_reg    <= '0;
      aux_reg          <= '0;
      aux_oe_reg       <= 1'b0;
      prdata_reg       <= '0;
      pready_reg       <= 1'b0;
      pslverr_reg      <= 1'b0;
    end else begin
      ref_ld_prev_reg  <= ref_ld_prev_next;
      ctrl_ld_prev_reg <= ctrl_ld_prev_next;
      config_reg       <= config_next;
      offset_a_reg     <= offset_a_next;
      offset_b_reg     <= offset_b_next;
      delay_reg        <= delay_next;
      soft_xfer_reg    <= soft_xfer_next;
      st_tail_reg      <= st_tail_next;
      sample_out_reg   <= sample_out_next;
      chain_out_reg    <= chain_out_next;
      aux_reg          <= aux_next;
      aux_oe_reg       <= aux_oe_next;
      prdata_reg       <= prdata_next;
      pready_reg       <= pready_next;
      pslverr_reg      <= pslverr_next;
    end
  end

  assign sample_bus_out  = sample_out_reg;
  assign chain_score_out = chain_out_reg;
  assign aux_bus_out     = aux_reg;
  assign aux_bus_oe      = aux_oe_reg;
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;

endmodule

`default_nettype wire

// ---- bench/corr_checker.sv ----
// Port-level assertions for the correlator array top.
`timescale 1ns/10ps
`default_nettype none

module corr_checker (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      prdata,
  input  wire logic             pready,
  input  wire logic             pslverr,
  input  wire logic             aux_out_en_n,
  input  wire logic             aux_bus_oe,
  input  wire corr_pkg::score_t chain_score_out
);
  import corr_pkg::*;
  logic [2:0] up_reg;
  logic [2:0] up_next;

  always_comb begin
    up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_reg <= 3'h0;
    end else begin
      up_reg <= up_next;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence setup_s;
    psel && !penable;
  endsequence

  sequence rd_s(logic [7:0] a);
    pready && !pwrite && paddr == a;
  endsequence

  pready_pulse_a: assert property (setup_s |=> pready ##1 !pready)
    else $error("pready is not a one-cycle answer");
  pready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without a setup cycle");
  err_unmap_a: assert property (pready && paddr > 8'h08 |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  err_map_a: assert property (pready && paddr <= 8'h08 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  ctrl_zero_a: assert property (rd_s(8'h00) |-> prdata == 32'h0000_0000)
    else $error("control word does not read zero");
  score_read_a: assert property (rd_s(8'h08) ##0 $stable(chain_score_out) |->
    prdata == {19'h0_0000, chain_score_out})
    else $error("score read differs from chain output");
  status_oe_a: assert property (rd_s(8'h04) ##0 $stable(aux_bus_oe) |->
    prdata[12] == aux_bus_oe && prdata[31:13] == 19'h0_0000)
    else $error("status enable bit wrong");
  oe_delay_a: assert property (up_reg == 3'h7 && $past(aux_out_en_n, 2) == $past(aux_out_en_n, 3)
    && $past(aux_out_en_n, 3) == $past(aux_out_en_n, 4) |-> aux_bus_oe == !$past(aux_out_en_n, 3))
    else $error("aux enable does not follow its pin");
endmodule

bind corr_top corr_checker chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .aux_out_en_n(aux_out_en_n), .aux_bus_oe(aux_bus_oe), .chain_score_out(chain_score_out)
);
`default_nettype wire

// ---- bench/host_model.sv ----
// Host controller model driving the reference, control and transfer pins.
`timescale 1ns/10ps
`default_nettype none

module host_model (
  input  wire logic           pclk,
  output var corr_pkg::byte_t ref_bus_in,
  output var corr_pkg::byte_t ctrl_bus_in,
  output logic                ref_load_n,
  output logic                ctrl_load_n,
  output logic [2:0]          ctrl_addr,
  output logic                array_transfer_n
);
  import corr_pkg::*;

  initial begin
    ref_bus_in = 8'h00;
    ctrl_bus_in = 8'h00;
    ref_load_n = 1'b1;
    ctrl_load_n = 1'b1;
    ctrl_addr = 3'h0;
    array_transfer_n = 1'b1;
  end

  task automatic strobe(input logic is_ref, input logic [2:0] a, input byte_t v);
    @(posedge pclk);
    if (is_ref) begin
      ref_bus_in <= v;
      ref_load_n <= 1'b0;
    end else begin
      ctrl_bus_in <= v;
      ctrl_addr <= a;
      ctrl_load_n <= 1'b0;
    end
    repeat (2) @(posedge pclk);
    ref_load_n <= 1'b1;
    ctrl_load_n <= 1'b1;
    repeat (3) @(posedge pclk);
    ref_bus_in <= ~ref_bus_in;
    ctrl_bus_in <= ~ctrl_bus_in;
    ctrl_addr <= ~ctrl_addr;
  endtask

  task automatic xfer();
    @(posedge pclk);
    array_transfer_n <= 1'b0;
    repeat (4) @(posedge pclk);
    array_transfer_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_binary_correlator_array.sv ----
// Self-checking bench for the correlator array top.
`timescale 1ns/10ps
`default_nettype none
`include "corr_defines.svh"

module tb_binary_correlator_array;
  import corr_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  byte_t       ref_bus_in;
  byte_t       ctrl_bus_in;
  logic        ref_load_n;
  logic        ctrl_load_n;
  logic [2:0]  ctrl_addr;
  logic        array_transfer_n;
  byte_t       sample_bus_in = 8'h00;
  score_t      chain_score_in = 13'h0000;
  logic        aux_out_en_n = 1'b1;
  byte_t       sample_bus_out;
  score_t      chain_score_out;
  aux_t        aux_bus_out;
  logic        aux_bus_oe;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          seed = 80348;
  int          cycles = 0;
  int          cfg, offa, offb, smp, chin, dly;
  int          pre[2][8];
  int          lat[2][8];

  always #5 pclk = ~pclk;

  corr_top dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ref_bus_in, .ref_load_n, .ctrl_bus_in, .ctrl_load_n, .ctrl_addr,
    .sample_bus_in, .chain_score_in, .array_transfer_n, .aux_out_en_n,
    .sample_bus_out, .chain_score_out, .aux_bus_out, .aux_bus_oe
  );

  host_model host_u (
    .pclk, .ref_bus_in, .ctrl_bus_in, .ref_load_n, .ctrl_load_n, .ctrl_addr,
    .array_transfer_n
  );

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check(rd, exp, "read data");
    check({31'h0, err}, {31'h0, a > 8'h08}, "slave error");
  endtask

  task automatic ctl(input logic [2:0] a, input int v);
    host_u.strobe(1'b0, a, v[7:0]);
  endtask

  task automatic fill(input logic is_ref, input int v);
    int b;
    for (int k = 0; k < 32; k++) begin
      b = cfg[0] ? v : (v & 128) | ($random(seed) & 127);
      host_u.strobe(is_ref, 3'h0, b[7:0]);
    end
    for (int i = 7; i > 0; i--) begin
      pre[is_ref][i] = cfg[0] ? v[7 - i] : pre[is_ref][i - 1];
    end
    pre[is_ref][0] = v[7];
  endtask

  task automatic new_sample();
    smp = $random(seed) & 255;
    sample_bus_in <= smp[7:0];
    repeat (300) @(posedge pclk);
  endtask

  task automatic expect_out();
    int c;
    int s;
    int sb;
    int ax;
    s = 0;
    sb = 0;
    ax = 0;
    for (int i = 0; i < 8; i++) begin
      c = ((cfg[0] ? smp[7 - i] : smp[7]) == lat[1][i] && lat[0][i] == 1) ? 32 : 0;
      if (cfg[1] && i > 3) begin
        sb += c;
      end else begin
        s += (cfg[0] && !cfg[1]) ? c << (7 - i) : c;
      end
      ax += pre[1][i] << (7 - i);
    end
    s = cfg[1] ? (s + offa) % 512 : (s + offa + chin) % 8192;
    ax = cfg[1] ? (sb + offb) % 512 : ax;
    check({19'h0, chain_score_out}, s, "chain score");
    check({23'h0, aux_bus_out}, ax, "aux bus");
    check({24'h0, sample_bus_out}, cfg[0] ? smp : smp & 128, "sample out");
    reg_chk(`CORR_REG_SCORE, s);
  endtask

  initial begin
    logic [31:0] rd;
    logic        err;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    reg_chk(`CORR_REG_STATUS, 32'h0000_0000);
    reg_chk(`CORR_REG_CTRL, 32'h0000_0000);
    reg_chk(`CORR_REG_SCORE, 32'h0000_0000);
    reg_chk(8'h0C, 32'h0000_0000);
    apb(1'b1, `CORR_REG_STATUS, 32'hFFFF_FFFF, rd, err);
    reg_chk(`CORR_REG_STATUS, 32'h0000_0000);
    $display("test registers done");
    cfg = 1;
    ctl(3'h1, cfg);
    offa = $random(seed) & 8191;
    ctl(3'h2, offa >> 8);
    ctl(3'h3, offa & 255);
    chin = $random(seed) & 8191;
    chain_score_in <= chin[12:0];
    new_sample();
    expect_out();
    $display("test masked array done");
    fill(1'b1, $random(seed));
    fill(1'b0, $random(seed));
    expect_out();
    host_u.xfer();
    lat = pre;
    new_sample();
    expect_out();
    $display("test window 8x32 done");
    cfg = 0;
    ctl(3'h1, cfg);
    new_sample();
    expect_out();
    fill(1'b1, $random(seed));
    apb(1'b1, `CORR_REG_CTRL, 32'h0000_0001, rd, err);
    lat = pre;
    new_sample();
    expect_out();
    $display("test window 1x256 done");
    cfg = 2;
    ctl(3'h1, cfg);
    offb = $random(seed) & 8191;
    ctl(3'h5, offb >> 8);
    ctl(3'h6, offb & 255);
    ctl(3'h7, 255);
    dly = $random(seed) & 15;
    ctl(3'h4, dly);
    aux_out_en_n <= 1'b0;
    new_sample();
    expect_out();
    check({31'h0, aux_bus_oe}, 1, "aux enable");
    reg_chk(`CORR_REG_STATUS, 4096 + (dly << 8) + cfg);
    $display("test dual done");
    stop_test();
  end
endmodule
`default_nettype wire
